//--- verilog/frame_policy_pkg.sv
// Purpose: shared constants and carriers for the frame transmit policy block
// Assumes: one 200 MHz clock, requests arrive one per handshake
// Notes: lin versions are coded major in the high nibble, minor in the low nibble
package frame_policy_pkg;
  // ==========================================================================
  // protocol and encodings
  typedef enum logic [1:0] {
    PROTO_CAN = 2'h0,
    PROTO_FLEXRAY = 2'h1,
    PROTO_LIN = 2'h2
  } proto_type;
  localparam logic periodic_timing_code = 1'h0;
  localparam logic event_timing_code = 1'h1;
  localparam logic checksum_kind_basic = 1'h0;
  localparam logic checksum_kind_extended = 1'h1;
  // ==========================================================================
  // identifier limits
  localparam logic [31:0] CAN_STD_ID_MAX = 32'h0000_07EF;
  localparam logic [31:0] CAN_EXT_ID_MAX = 32'h1FFF_FFFF;
  localparam logic [31:0] SLOT_ID_MIN = 32'h0000_0001;
  localparam logic [31:0] SLOT_ID_MAX = 32'h0000_07FF;
  localparam logic [31:0] LIN_ID_MAX = 32'h0000_003F;
  localparam logic [5:0] LIN_DIAG_ID_A = 6'h3C;
  localparam logic [5:0] LIN_DIAG_ID_B = 6'h3D;
  localparam logic [7:0] LIN_VER_ENHANCED = 8'h20;
  localparam int PAYLOAD_BITS = 64;
  localparam int MUX_VAL_BITS = 8;
  localparam int SIG_REF_BITS = 16;
  localparam logic [SIG_REF_BITS-1:0] NO_MUX_REF = 16'h0000;
  // ==========================================================================
  // carriers
  typedef struct packed {
    proto_type proto;
    logic [31:0] frame_identifier;
    logic ext_id;
    logic timing_set;
    logic slot_timing_select;
    logic [10:0] static_slot_count;
    logic new_data;
    logic event_pending;
    logic [7:0] lin_ver_tx;
    logic [7:0] lin_ver_rx;
    logic has_mux;
    logic [SIG_REF_BITS-1:0] mux_sig_ref;
    logic [MUX_VAL_BITS-1:0] mux_value;
    logic [MUX_VAL_BITS-1:0] dyn_group_sel;
    logic [PAYLOAD_BITS-1:0] static_mask;
    logic [PAYLOAD_BITS-1:0] static_data;
    logic [PAYLOAD_BITS-1:0] dyn_mask;
    logic [PAYLOAD_BITS-1:0] dyn_data;
  } frame_req_type;
  typedef struct packed {
    proto_type proto;
    logic [31:0] frame_identifier;
    logic send;
    logic null_frame;
    logic payload_valid;
    logic static_seg;
    logic timing_eff;
    logic id_error;
    logic checksum_kind;
    logic [7:0] protected_id;
    logic frame_multiplexed_flag;
    logic [SIG_REF_BITS-1:0] multiplexer_signal_ref;
    logic [PAYLOAD_BITS-1:0] payload;
  } frame_dec_type;
endpackage

//--- verilog/frame_tx_policy.sv
// Purpose: per-frame transmit decision, identifier check, checksum pick, mux payload
// Assumes: inputs synchronous to CLK_I; caller holds REQ_I while REQ_VALID_I and not ready
// Notes: decisions leave through a two-entry buffer so a receiver stall loses nothing
`timescale 1ns/1ps
module frame_tx_policy #(
  parameter int PAYLOAD_W = frame_policy_pkg::PAYLOAD_BITS
) (
  input wire logic CLK_I,
  input wire logic NRST_I,
  input wire logic REQ_VALID_I,
  input wire frame_policy_pkg::frame_req_type REQ_I,
  output logic REQ_READY_O,
  output logic DEC_VALID_O,
  input wire logic DEC_READY_I,
  output frame_policy_pkg::frame_dec_type DEC_O,
  input wire logic CFG_ERR_CLR_I,
  output logic CFG_ERR_O
);
  import frame_policy_pkg::*;

  // ==========================================================================
  // elaboration check
  generate
    if (PAYLOAD_W != PAYLOAD_BITS) begin : g_bad_width
      $error("payload width must match the carrier width");
    end
  endgenerate

  // ==========================================================================
  // decision logic
  logic static_seg;
  logic timing_eff;
  logic id_err;
  logic [7:0] ver_min;
  logic [5:0] lin_id;
  logic [7:0] pid;
  logic [PAYLOAD_W-1:0] fresh_payload;
  frame_dec_type dec;
  logic [PAYLOAD_W-1:0] last_payload_ff;
  logic [PAYLOAD_W-1:0] nxt_last_payload;
  logic upd_last;

  always_comb begin
    static_seg = (REQ_I.frame_identifier <= {21'h00_0000, REQ_I.static_slot_count});
    if (REQ_I.timing_set) begin
      timing_eff = REQ_I.slot_timing_select;
    end else begin
      timing_eff = static_seg ? periodic_timing_code : event_timing_code;
    end
    unique case (REQ_I.proto)
      PROTO_CAN: begin
        if (REQ_I.ext_id) begin
          id_err = (REQ_I.frame_identifier > CAN_EXT_ID_MAX);
        end else begin
          id_err = (REQ_I.frame_identifier > CAN_STD_ID_MAX);
        end
      end
      PROTO_FLEXRAY: begin
        id_err = (REQ_I.frame_identifier < SLOT_ID_MIN) ||
                 (REQ_I.frame_identifier > SLOT_ID_MAX);
      end
      PROTO_LIN: begin
        id_err = (REQ_I.frame_identifier > LIN_ID_MAX);
      end
      default: begin
        id_err = 1'b1;
      end
    endcase
    lin_id = REQ_I.frame_identifier[5:0];
    // parity bits form the protected identifier that the extended sum covers
    pid = {~(lin_id[1] ^ lin_id[3] ^ lin_id[4] ^ lin_id[5]),
           lin_id[0] ^ lin_id[1] ^ lin_id[2] ^ lin_id[4], lin_id};
    ver_min = (REQ_I.lin_ver_tx < REQ_I.lin_ver_rx) ? REQ_I.lin_ver_tx : REQ_I.lin_ver_rx;
    // static signals always, one subframe group only when unmuxed or the mux value names it
    fresh_payload = REQ_I.static_data & REQ_I.static_mask;
    if (!REQ_I.has_mux || (REQ_I.dyn_group_sel == REQ_I.mux_value)) begin
      fresh_payload = fresh_payload | (REQ_I.dyn_data & REQ_I.dyn_mask);
    end

    dec = '0;
    dec.proto = REQ_I.proto;
    dec.frame_identifier = REQ_I.frame_identifier;
    dec.id_error = id_err;
    dec.static_seg = static_seg;
    dec.timing_eff = timing_eff;
    dec.protected_id = pid;
    dec.frame_multiplexed_flag = REQ_I.has_mux;
    dec.multiplexer_signal_ref = REQ_I.has_mux ? REQ_I.mux_sig_ref : NO_MUX_REF;
    if ((lin_id == LIN_DIAG_ID_A) || (lin_id == LIN_DIAG_ID_B)) begin
      dec.checksum_kind = checksum_kind_basic;
    end else if (ver_min >= LIN_VER_ENHANCED) begin
      dec.checksum_kind = checksum_kind_extended;
    end else begin
      dec.checksum_kind = checksum_kind_basic;
    end
    dec.send = 1'b0;
    dec.null_frame = 1'b0;
    dec.payload_valid = 1'b0;
    dec.payload = '0;
    upd_last = 1'b0;
    if (id_err) begin
      // a bad identifier never reaches the bus
      dec.send = 1'b0;
    end else if (REQ_I.proto != PROTO_FLEXRAY) begin
      dec.send = 1'b1;
      dec.payload_valid = 1'b1;
      dec.payload = fresh_payload;
    end else if (static_seg && (timing_eff == periodic_timing_code)) begin
      dec.send = 1'b1;
      dec.payload_valid = 1'b1;
      dec.payload = REQ_I.new_data ? fresh_payload : last_payload_ff;
      upd_last = 1'b1;
    end else if (static_seg) begin
      dec.send = 1'b1;
      dec.null_frame = !REQ_I.event_pending;
      dec.payload_valid = REQ_I.event_pending;
      dec.payload = REQ_I.event_pending ? fresh_payload : '0;
    end else if (timing_eff == periodic_timing_code) begin
      dec.send = 1'b1;
      dec.payload_valid = 1'b1;
      dec.payload = fresh_payload;
    end else begin
      dec.send = REQ_I.event_pending;
      dec.payload_valid = REQ_I.event_pending;
      dec.payload = REQ_I.event_pending ? fresh_payload : '0;
    end
  end

  // ==========================================================================
  // two-entry buffer, head drives the outputs directly
  frame_dec_type head_ff;
  frame_dec_type tail_ff;
  logic head_v_ff;
  logic tail_v_ff;
  logic ready_ff;
  logic err_ff;
  frame_dec_type nxt_head;
  frame_dec_type nxt_tail;
  logic nxt_head_v;
  logic nxt_tail_v;
  logic nxt_ready;
  logic nxt_err;
  logic push;
  logic pop;

  always_comb begin
    push = REQ_VALID_I && ready_ff;
    pop = head_v_ff && DEC_READY_I;
    nxt_head = head_ff;
    nxt_tail = tail_ff;
    nxt_head_v = head_v_ff;
    nxt_tail_v = tail_v_ff;
    if (pop) begin
      nxt_head = tail_ff;
      nxt_head_v = tail_v_ff;
      nxt_tail_v = 1'b0;
    end
    if (push) begin
      if (!nxt_head_v) begin
        nxt_head = dec;
        nxt_head_v = 1'b1;
      end else begin
        nxt_tail = dec;
        nxt_tail_v = 1'b1;
      end
    end
    // ready only while a slot stays free, so a stalled receiver drops nothing
    nxt_ready = !nxt_tail_v;
    // a new error in the clear cycle wins over the clear
    nxt_err = (err_ff && !CFG_ERR_CLR_I) || (push && id_err);
    // only a taken periodic static request may move the resend memory
    nxt_last_payload = last_payload_ff;
    if (push && upd_last) begin
      nxt_last_payload = dec.payload;
    end
  end

  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      head_ff <= '0;
      tail_ff <= '0;
      head_v_ff <= 1'b0;
      tail_v_ff <= 1'b0;
      ready_ff <= 1'b0;
      err_ff <= 1'b0;
      last_payload_ff <= '0;
    end else begin
      head_ff <= nxt_head;
      tail_ff <= nxt_tail;
      head_v_ff <= nxt_head_v;
      tail_v_ff <= nxt_tail_v;
      ready_ff <= nxt_ready;
      err_ff <= nxt_err;
      last_payload_ff <= nxt_last_payload;
    end
  end

  assign REQ_READY_O = ready_ff;
  assign DEC_VALID_O = head_v_ff;
  assign DEC_O = head_ff;
  assign CFG_ERR_O = err_ff;

  // ==========================================================================
  // assertions
  property p_null_only_static_event;
    @(posedge CLK_I) disable iff (!NRST_I)
      DEC_VALID_O && DEC_O.null_frame |->
        DEC_O.static_seg && (DEC_O.timing_eff == event_timing_code);
  endproperty
  a_null_only_static_event: assert property (p_null_only_static_event)
    else $error("null frame outside static event timing");

  property p_null_marks_invalid;
    @(posedge CLK_I) disable iff (!NRST_I)
      DEC_VALID_O && DEC_O.null_frame |-> DEC_O.send && !DEC_O.payload_valid;
  endproperty
  a_null_marks_invalid: assert property (p_null_marks_invalid)
    else $error("null frame not sent or payload still valid");

  property p_static_event_null;
    @(posedge CLK_I) disable iff (!NRST_I)
      push && !id_err && REQ_I.proto == PROTO_FLEXRAY && static_seg &&
      timing_eff == event_timing_code && !REQ_I.event_pending && !head_v_ff
      |=> DEC_VALID_O && DEC_O.null_frame;
  endproperty
  a_static_event_null: assert property (p_static_event_null)
    else $error("missing null frame for idle static event slot");

  property p_dyn_periodic_sent;
    @(posedge CLK_I) disable iff (!NRST_I)
      DEC_VALID_O && DEC_O.proto == PROTO_FLEXRAY && !DEC_O.id_error &&
      !DEC_O.static_seg && DEC_O.timing_eff == periodic_timing_code |-> DEC_O.send;
  endproperty
  a_dyn_periodic_sent: assert property (p_dyn_periodic_sent)
    else $error("dynamic periodic frame not sent");

  property p_dyn_event_idle;
    @(posedge CLK_I) disable iff (!NRST_I)
      DEC_VALID_O && !DEC_O.static_seg && DEC_O.proto == PROTO_FLEXRAY &&
      DEC_O.timing_eff == event_timing_code |-> !DEC_O.null_frame;
  endproperty
  a_dyn_event_idle: assert property (p_dyn_event_idle)
    else $error("dynamic event frame produced a null frame");

  property p_default_timing;
    @(posedge CLK_I) disable iff (!NRST_I)
      push && !REQ_I.timing_set && !head_v_ff |=>
        DEC_O.timing_eff == !DEC_O.static_seg;
  endproperty
  a_default_timing: assert property (p_default_timing)
    else $error("default timing does not follow segment");

  property p_err_sticky;
    @(posedge CLK_I) disable iff (!NRST_I)
      push && id_err |=> CFG_ERR_O ##1 (CFG_ERR_O || $past(CFG_ERR_CLR_I));
  endproperty
  a_err_sticky: assert property (p_err_sticky)
    else $error("configuration error not raised or not held");

  property p_diag_basic;
    @(posedge CLK_I) disable iff (!NRST_I)
      DEC_VALID_O && (DEC_O.frame_identifier[5:0] == LIN_DIAG_ID_A ||
      DEC_O.frame_identifier[5:0] == LIN_DIAG_ID_B) |->
        DEC_O.checksum_kind == checksum_kind_basic;
  endproperty
  a_diag_basic: assert property (p_diag_basic)
    else $error("diagnostic frame uses extended checksum");

  property p_mux_ref;
    @(posedge CLK_I) disable iff (!NRST_I)
      DEC_VALID_O |-> (DEC_O.frame_multiplexed_flag ||
        DEC_O.multiplexer_signal_ref == NO_MUX_REF);
  endproperty
  a_mux_ref: assert property (p_mux_ref)
    else $error("multiplexer reference set on a plain frame");

  property p_no_loss;
    @(posedge CLK_I) disable iff (!NRST_I)
      tail_v_ff && !DEC_READY_I |=> tail_v_ff && !REQ_READY_O && $stable(DEC_O);
  endproperty
  a_no_loss: assert property (p_no_loss)
    else $error("buffer changed while full and stalled");
endmodule

//--- bench/dec_sink.sv
// Purpose: consumer of the decision stream, standing in for the bus side
// Assumes: mode 0 prompt, 1 slow (ready every other cycle), 2 stalled
// Notes: ready is registered so the stall pattern never races the head entry
`timescale 1ns/1ps
module dec_sink (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic [1:0] mode_i,
  output logic ready_o
);
  // ==========================================================================
  // ready pattern
  logic nxt_ready;
  logic ready_ff;
  always_comb begin
    nxt_ready = 1'b0;
    if (mode_i == 2'h0) begin
      nxt_ready = 1'b1;
    end else if (mode_i == 2'h1) begin
      nxt_ready = ~ready_ff;
    end
  end
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ready_ff <= 1'b0;
    end else begin
      ready_ff <= nxt_ready;
    end
  end
  assign ready_o = ready_ff;
endmodule

//--- bench/tb_frame_tx_policy.sv
// Purpose: self-checking bench for the frame transmit policy block
// Assumes: static slot count 10, mux value 3, versions coded as nibbles
// Notes: payload is static half low, dynamic half high, tagged by row index
`timescale 1ns/1ps
module tb_frame_tx_policy;
  import frame_policy_pkg::*;
  typedef struct {frame_req_type req; logic [5:0] e;} row_type;
  logic CLK_I, NRST_I, REQ_VALID_I, REQ_READY_O, DEC_VALID_O, DEC_READY_I;
  logic CFG_ERR_CLR_I, CFG_ERR_O, incl;
  frame_req_type REQ_I, b;
  frame_dec_type DEC_O, d;
  frame_dec_type got[$];
  row_type rows[$];
  row_type r;
  logic [1:0] mode;
  logic [7:0] idx;
  logic [5:0] care;
  logic [63:0] ep, last;
  int err_count = 0;
  int n_tests = 0;
  // ==========================================================================
  // design and far side
  frame_tx_policy uut (.CLK_I(CLK_I), .NRST_I(NRST_I), .REQ_VALID_I(REQ_VALID_I),
    .REQ_I(REQ_I), .REQ_READY_O(REQ_READY_O), .DEC_VALID_O(DEC_VALID_O),
    .DEC_READY_I(DEC_READY_I), .DEC_O(DEC_O), .CFG_ERR_CLR_I(CFG_ERR_CLR_I),
    .CFG_ERR_O(CFG_ERR_O));
  dec_sink sink (.clk_i(CLK_I), .nrst_i(NRST_I), .mode_i(mode), .ready_o(DEC_READY_I));
  initial begin
    CLK_I = 1'b0;
    forever #2.5 CLK_I = ~CLK_I;
  end
  always @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) got.delete();
    else if (DEC_VALID_O === 1'b1 && DEC_READY_I === 1'b1) got.push_back(DEC_O);
  end
  // ==========================================================================
  // tasks
  task automatic check(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // called at a rising edge; returns at the edge that took the request
  task automatic send(input frame_req_type q);
    int k;
    k = 0;
    REQ_I <= q;
    REQ_VALID_I <= 1'b1;
    @(negedge CLK_I);
    while (REQ_READY_O !== 1'b1 && k < 50) begin
      @(negedge CLK_I);
      k++;
    end
    if (k >= 50) begin
      err_count++;
      end_of_test();
    end
    @(posedge CLK_I);
  endtask
  task automatic wait_got(input int n);
    int k;
    k = 0;
    while (got.size() < n && k < 50) begin
      @(negedge CLK_I);
      k++;
    end
    if (k >= 50) begin
      err_count++;
      end_of_test();
    end
  endtask
  // e holds send, null, static, event timing, id error, extended checksum
  task automatic add(input int p, input logic [31:0] id, input logic x, ts, tl, nd, ev,
    input logic [15:0] v, input logic m, input logic [7:0] s, input logic [5:0] e);
    row_type w;
    w.req = '0;
    w.req.proto = proto_type'(p);
    w.req.frame_identifier = id;
    w.req.ext_id = x;
    w.req.timing_set = ts;
    w.req.slot_timing_select = tl;
    w.req.new_data = nd;
    w.req.event_pending = ev;
    w.req.static_slot_count = 11'h00A;
    w.req.lin_ver_tx = v[15:8];
    w.req.lin_ver_rx = v[7:0];
    w.req.has_mux = m;
    w.req.mux_sig_ref = 16'h0042;
    w.req.mux_value = 8'h03;
    w.req.dyn_group_sel = s;
    w.e = e;
    rows.push_back(w);
  endtask
  // ==========================================================================
  // main sequence
  initial begin
    NRST_I = 1'b0;
    REQ_VALID_I = 1'b0;
    REQ_I = '0;
    CFG_ERR_CLR_I = 1'b0;
    mode = 2'h0;
    last = '0;
    repeat (6) @(posedge CLK_I);
    check("rst_ready", REQ_READY_O, 1'b0);
    check("rst_valid", DEC_VALID_O, 1'b0);
    NRST_I <= 1'b1;
    add(1, 5, 0, 1, 0, 1, 0, 0, 0, 3, 6'b101000);
    add(1, 10, 0, 1, 0, 0, 0, 0, 0, 3, 6'b101000);
    add(1, 7, 0, 1, 1, 1, 0, 0, 0, 3, 6'b111100);
    add(1, 7, 0, 1, 1, 1, 1, 0, 0, 3, 6'b101100);
    add(1, 11, 0, 1, 0, 1, 0, 0, 0, 3, 6'b100000);
    add(1, 11, 0, 1, 1, 1, 0, 0, 0, 3, 6'b000100);
    add(1, 12, 0, 1, 1, 1, 1, 0, 0, 3, 6'b100100);
    add(1, 3, 0, 0, 1, 1, 0, 0, 0, 3, 6'b101000);
    add(1, 2047, 0, 0, 0, 1, 0, 0, 0, 3, 6'b000100);
    add(1, 1, 0, 1, 0, 1, 0, 0, 0, 3, 6'b101000);
    add(1, 0, 0, 1, 0, 1, 0, 0, 0, 3, 6'b000010);
    add(1, 2048, 0, 1, 0, 1, 0, 0, 0, 3, 6'b000010);
    add(0, 2031, 0, 0, 0, 1, 0, 0, 0, 3, 6'b100000);
    add(0, 2032, 0, 0, 0, 1, 0, 0, 0, 3, 6'b000010);
    add(0, 2047, 0, 0, 0, 1, 0, 0, 0, 3, 6'b000010);
    add(0, 2032, 1, 0, 0, 1, 0, 0, 0, 3, 6'b100000);
    add(0, 32'h1FFF_FFFF, 1, 0, 0, 1, 0, 0, 0, 3, 6'b100000);
    add(0, 32'h2000_0000, 1, 0, 0, 1, 0, 0, 0, 3, 6'b000010);
    add(2, 63, 0, 0, 0, 1, 0, 16'h2021, 0, 3, 6'b100001);
    add(2, 64, 0, 0, 0, 1, 0, 16'h2020, 0, 3, 6'b000010);
    add(2, 60, 0, 0, 0, 1, 0, 16'h2020, 0, 3, 6'b100000);
    add(2, 61, 0, 0, 0, 1, 0, 16'h2121, 0, 3, 6'b100000);
    add(2, 5, 0, 0, 0, 1, 0, 16'h2013, 0, 3, 6'b100000);
    add(2, 5, 0, 0, 0, 1, 0, 16'h1F30, 0, 3, 6'b100000);
    add(2, 0, 0, 0, 0, 1, 0, 16'h2020, 1, 3, 6'b100001);
    add(2, 1, 0, 0, 0, 1, 0, 16'h2020, 1, 4, 6'b100001);
    add(0, 1, 0, 0, 0, 1, 0, 0, 0, 4, 6'b100000);
    for (int i = 0; i < rows.size(); i++) begin
      r = rows[i];
      idx = 8'(i);
      r.req.static_mask = 64'h0000_0000_FFFF_FFFF;
      r.req.dyn_mask = 64'hFFFF_FFFF_0000_0000;
      r.req.static_data = {32'h5A5A_0000, 24'h00_0000, idx};
      r.req.dyn_data = {24'h00_0000, idx, 32'hFFFF_FFFF};
      care = r.e[1] ? 6'b100010 : (r.req.proto == PROTO_FLEXRAY ? 6'b111111 : 6'b110011);
      incl = !r.req.has_mux || r.req.dyn_group_sel == r.req.mux_value;
      ep = {incl ? {24'h00_0000, idx} : 32'h0000_0000, 24'h00_0000, idx};
      // stale payload memory only matters for periodic static slots
      if (r.req.proto == PROTO_FLEXRAY && r.e[3] && !r.e[2] && !r.e[1]) begin
        if (r.req.new_data) last = ep;
        else ep = last;
      end
      @(posedge CLK_I);
      send(r.req);
      REQ_VALID_I <= 1'b0;
      wait_got(1);
      d = got.pop_front();
      check("flags", {d.send, d.null_frame, d.static_seg, d.timing_eff, d.id_error,
        d.checksum_kind} & care, r.e & care);
      if (!r.e[1]) begin
        check("pl_valid", d.payload_valid, r.e[5] & !r.e[4]);
        check("mux_flag", d.frame_multiplexed_flag, r.req.has_mux);
        check("mux_ref", d.multiplexer_signal_ref, r.req.has_mux ? 16'h0042 : NO_MUX_REF);
        check("slot", d.frame_identifier, r.req.frame_identifier);
      end
      if (r.e[5] && !r.e[4] && !r.e[1]) check("payload", d.payload, ep);
      if (r.req.proto == PROTO_LIN && r.e[5] && r.req.frame_identifier[5:1] == 5'h1E)
        check("pid", d.protected_id, r.req.frame_identifier[0] ? 8'h7D : 8'h3C);
      @(negedge CLK_I);
      check("cfg_err", CFG_ERR_O, r.e[1]);
      @(posedge CLK_I);
      CFG_ERR_CLR_I <= 1'b1;
      @(posedge CLK_I);
      CFG_ERR_CLR_I <= 1'b0;
      @(negedge CLK_I);
      check("cfg_clr", CFG_ERR_O, 1'b0);
    end
    // receiver stalled: two entries held, third refused until drained
    @(posedge CLK_I);
    mode <= 2'h2;
    b = rows[0].req;
    b.frame_identifier = 32'h0000_0015;
    send(b);
    b.frame_identifier = 32'h0000_0016;
    send(b);
    REQ_VALID_I <= 1'b0;
    repeat (3) @(negedge CLK_I);
    check("full", REQ_READY_O, 1'b0);
    check("held", DEC_VALID_O, 1'b1);
    @(posedge CLK_I);
    mode <= 2'h1;
    b.frame_identifier = 32'h0000_0017;
    send(b);
    REQ_VALID_I <= 1'b0;
    wait_got(3);
    for (int k = 0; k < 3; k++) check("order", got[k].frame_identifier, 32'h15 + k);
    // reset in mid-run wipes held entries and the sticky error
    @(posedge CLK_I);
    mode <= 2'h2;
    b.frame_identifier = 32'h0000_0000;
    send(b);
    REQ_VALID_I <= 1'b0;
    repeat (3) @(negedge CLK_I);
    check("err_set", CFG_ERR_O, 1'b1);
    @(posedge CLK_I);
    NRST_I <= 1'b0;
    @(negedge CLK_I);
    check("rst2_valid", DEC_VALID_O, 1'b0);
    check("rst2_err", CFG_ERR_O, 1'b0);
    @(posedge CLK_I);
    NRST_I <= 1'b1;
    mode <= 2'h0;
    @(negedge CLK_I);
    check("rst2_ready_lo", REQ_READY_O, 1'b0);
    @(negedge CLK_I);
    check("rst2_ready_hi", REQ_READY_O, 1'b1);
    @(posedge CLK_I);
    send(rows[12].req);
    REQ_VALID_I <= 1'b0;
    wait_got(1);
    d = got.pop_front();
    check("rst2_send", {d.send, d.id_error}, 2'b10);
    @(negedge CLK_I);
    check("rst2_err_clean", CFG_ERR_O, 1'b0);
    end_of_test();
  end
endmodule
